// File: core/pssp_if.sv
// Pin bundle between memory controller and SRAM port.
// Assumes both ends run on the same mclk; shared data lines resolved here.
`timescale 1ns/1ns
interface pssp_if;
  import pssp_pkg::*;
  logic                clk_qualify_n;
  logic                chip_sel_a_n;
  logic                chip_sel_b;
  logic                chip_sel_c_n;
  logic                advance_or_load;
  logic                write_n;
  logic [LANES-1:0]    byte_lane_write_n;
  logic [ADDR_W-1:0]   addr;
  logic                burst_mode;
  logic                sleep_request;
  logic                out_drive_n;
  logic [DATA_W-1:0]   host_data;
  logic [LANES-1:0]    host_parity;
  logic                host_drive_en;
  logic [DATA_W-1:0]   dev_data;
  logic [LANES-1:0]    dev_parity;
  logic                dev_drive_en;
  logic [DATA_W-1:0]   data_bus;
  logic [LANES-1:0]    parity_lines;

  // Wire level from the device enable alone; device wins on a clash
  assign data_bus     = dev_drive_en ? dev_data : host_data;
  assign parity_lines = dev_drive_en ? dev_parity : host_parity;

  modport device (
    input  clk_qualify_n, chip_sel_a_n, chip_sel_b, chip_sel_c_n,
    input  advance_or_load, write_n, byte_lane_write_n, addr,
    input  burst_mode, sleep_request, out_drive_n, data_bus, parity_lines,
    output dev_data, dev_parity, dev_drive_en
  );
  modport host (
    output clk_qualify_n, chip_sel_a_n, chip_sel_b, chip_sel_c_n,
    output advance_or_load, write_n, byte_lane_write_n, addr,
    output burst_mode, sleep_request, out_drive_n,
    output host_data, host_parity, host_drive_en,
    input  data_bus, parity_lines
  );
endinterface : pssp_if

// File: core/pssp_pkg.sv
// Shared constants and types for the pipelined synchronous SRAM port.
// Assumes a single 50 MHz clock shared by both ends.
package pssp_pkg;
  localparam int ADDR_W    = 17;
  localparam int LANES     = 4;
  localparam int LANE_W    = 8;
  localparam int DATA_W    = LANES * LANE_W;
  localparam int SLOT_W    = LANE_W + 1;
  localparam int WORD_W    = LANES * SLOT_W;
  localparam int BUF_DEPTH = 2;
  localparam int CNT_W     = 3;

  localparam int BURST_W             = 2;
  localparam logic [1:0] BURST_STEP  = 2'h1;
  localparam logic [1:0] BURST_FIRST = 2'h0;

  // Values after reset
  localparam logic       SYNC_OE_RST   = 1'b1;
  localparam logic       SYNC_MODE_RST = 1'b1;
  localparam logic [3:0] BW_IDLE       = 4'hf;

  typedef enum logic [1:0] {
    PSSP_IDLE,
    PSSP_READ,
    PSSP_WRITE
  } pssp_op_t;
endpackage : pssp_pkg

// File: core/pssp_sram_dev.sv
// SRAM end: pipelined burst memory with byte-lane writes and parity lanes.
// Assumes the controller keeps the pin timing and mclk is common to both ends.
//
// Notes on behaviour
// [RULE1] Qualifier high freezes all state; sleep clearing, pin synchronizers and strap flop still update
// [RULE2] Qualifier high stretches cycle, never deselects
// [RULE3] Sleep input keeps contents, normally low
// [RULE4] Input data captured at rising edge
// [RULE5] Output drive needs enable low
// [RULE6] Tristate on write data, deselect, restart
// [RULE7] Parity lanes follow their byte selects
// [RULE8] Strap picks linear or interleaved order
// [RULE9] Synchronous inputs registered before use
// [RULE10] Read data from output registers
// [RULE11] All selects and load start access
// [RULE12] Write strobe low writes, high reads
// [RULE13] Only selected byte lanes written
// [RULE14] Array write timed internally
// [RULE15] Deselect pipelined like reads
// [RULE16] Controller loads address after deselect
// [RULE17] Advance steps burst counter, load loads
// [RULE18] Two-bit counter wraps, keeps access type
// [RULE19] Read data after following edge
// [RULE20] Write data two edges after command
// [RULE21] Word is four lanes of nine bits
`timescale 1ns/1ns
module pssp_sram_dev #(
  parameter int ADDR_W = pssp_pkg::ADDR_W
) (
  input  wire logic   mclk,
  input  wire logic   resetn,
  pssp_if.device      bus,
  output logic        sleeping,
  output logic        interleaved,
  output logic        driving
);
  import pssp_pkg::*;

  localparam int DEPTH = 2 ** ADDR_W;

  // Storage: lane i holds {parity, byte}
  logic [WORD_W-1:0] mem [0:DEPTH-1]; // [RULE21]

  // Asynchronous pins, two flops each
  logic [1:0] sleep_sync;
  logic [1:0] oe_sync;
  logic [1:0] mode_sync;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sleep_sync <= 2'h0;
      oe_sync    <= {2{SYNC_OE_RST}};
      mode_sync  <= {2{SYNC_MODE_RST}};
    end else begin
      sleep_sync <= {sleep_sync[0], bus.sleep_request};
      oe_sync    <= {oe_sync[0], bus.out_drive_n};
      mode_sync  <= {mode_sync[0], bus.burst_mode};
    end
  end

  wire sleep_now = sleep_sync[1]; // [RULE3]
  wire oe_n_now  = oe_sync[1];

  // Strap caught after reset release
  logic order_ilv;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      order_ilv <= SYNC_MODE_RST;
    end else begin
      order_ilv <= mode_sync[1]; // [RULE8]
    end
  end

  // Clock qualifier gates the stage 1 and stage 2 updates; sleep clearing and the pin synchronizers ignore it
  wire ce = ~bus.clk_qualify_n; // [RULE1] [RULE2]

  // Decode of the sampled pins
  wire sel_all = ~bus.chip_sel_a_n & bus.chip_sel_b & ~bus.chip_sel_c_n;
  wire do_load = ~bus.advance_or_load;
  wire load_op_is_wr = ~bus.write_n; // [RULE12]

  pssp_op_t load_op;
  assign load_op = !sel_all ? PSSP_IDLE :
                   (load_op_is_wr ? PSSP_WRITE : PSSP_READ); // [RULE11]

  // Stage 1: registered inputs and burst state
  pssp_op_t                op1;
  pssp_op_t                burst_kind;
  logic [ADDR_W-1:0]       addr_base;
  logic [BURST_W-1:0]      burst_cnt;
  logic [LANES-1:0]        bw1_n;

  wire [BURST_W-1:0] base_lo = addr_base[BURST_W-1:0];
  wire [BURST_W-1:0] lin_lo  = base_lo + burst_cnt;
  wire [BURST_W-1:0] ilv_lo  = base_lo ^ burst_cnt;
  wire [BURST_W-1:0] cur_lo  = order_ilv ? ilv_lo : lin_lo; // [RULE8] [RULE18]
  wire [ADDR_W-1:0]  addr1   = {addr_base[ADDR_W-1:BURST_W], cur_lo};

  pssp_op_t next_op1;
  assign next_op1 = sleep_now ? PSSP_IDLE :
                    (do_load ? load_op : burst_kind); // [RULE17] [RULE18]

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      op1        <= PSSP_IDLE;
      burst_kind <= PSSP_IDLE;
      addr_base  <= '0;
      burst_cnt  <= BURST_FIRST;
      bw1_n      <= BW_IDLE;
    end else if (sleep_now) begin
      op1        <= PSSP_IDLE;
      burst_kind <= PSSP_IDLE;
    end else if (ce) begin // [RULE9]
      op1   <= next_op1;
      bw1_n <= bus.byte_lane_write_n;
      if (do_load) begin // [RULE11] [RULE17]
        burst_kind <= load_op;
        addr_base  <= bus.addr;
        burst_cnt  <= BURST_FIRST;
      end else begin
        burst_cnt <= burst_cnt + BURST_STEP; // [RULE17] [RULE18]
      end
    end
  end

  // Array read path, lane by lane
  wire [WORD_W-1:0] rd_word = mem[addr1];
  logic [DATA_W-1:0] rd_data;
  logic [LANES-1:0]  rd_par;

  // Stage 2: output register and write-data slot
  pssp_op_t          op2;
  logic [ADDR_W-1:0] addr2;
  logic [LANES-1:0]  bw2_n;
  logic [DATA_W-1:0] dout;
  logic [LANES-1:0]  dout_par;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      op2      <= PSSP_IDLE;
      addr2    <= '0;
      bw2_n    <= BW_IDLE;
      dout     <= '0;
      dout_par <= '0;
    end else if (sleep_now) begin
      op2 <= PSSP_IDLE;
    end else if (ce) begin
      op2   <= op1; // [RULE15]
      addr2 <= addr1;
      bw2_n <= bw1_n;
      if (op1 == PSSP_READ) begin // [RULE19]
        dout     <= rd_data; // [RULE10]
        dout_par <= rd_par;
      end
    end
  end

  // Write completes at the edge two after the command
  wire wr_now = ce & ~sleep_now & (op2 == PSSP_WRITE); // [RULE14] [RULE20]

  // Read of the word being written takes the bus lanes, so no stale data
  wire fwd_hit = wr_now & (addr2 == addr1);

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      wire lane_fwd = fwd_hit & ~bw2_n[g]; // [RULE13]
      assign rd_data[g*LANE_W +: LANE_W] = lane_fwd ? bus.data_bus[g*LANE_W +: LANE_W]
                                                    : rd_word[g*SLOT_W +: LANE_W];
      assign rd_par[g]                   = lane_fwd ? bus.parity_lines[g]
                                                    : rd_word[g*SLOT_W + LANE_W];
    end
  endgenerate

  // Selected lanes land in the array at the write edge
  always_ff @(posedge mclk) begin
    if (wr_now) begin
      for (int i = 0; i < LANES; i++) begin
        if (!bw2_n[i]) begin // [RULE13] [RULE7]
          mem[addr2][i*SLOT_W +: SLOT_W] <=
            {bus.parity_lines[i], bus.data_bus[i*LANE_W +: LANE_W]}; // [RULE4]
        end
      end
    end
  end

  // Drive only for a read in its data cycle
  wire read_slot = (op2 == PSSP_READ); // [RULE6] [RULE15]
  assign bus.dev_drive_en = read_slot & ~oe_n_now; // [RULE5]
  assign bus.dev_data     = dout;
  assign bus.dev_parity   = dout_par; // [RULE7]

  assign sleeping    = sleep_now;
  assign interleaved = order_ilv;
  assign driving     = bus.dev_drive_en;
endmodule : pssp_sram_dev

// File: core/pssp_sram_host.sv
// Controller end: issues accesses onto the SRAM pins, buffers read data.
// Assumes the SRAM end samples the same mclk; user side is valid/ready.
`timescale 1ns/1ns
module pssp_sram_host #(
  parameter int  ADDR_W      = pssp_pkg::ADDR_W,
  parameter int  BUF_DEPTH   = pssp_pkg::BUF_DEPTH,
  parameter bit  INTERLEAVED = 1'b1
) (
  input  wire logic                          mclk,
  input  wire logic                          resetn,
  pssp_if.host                               bus,
  input  wire logic                          cmd_valid,
  output logic                               cmd_ready,
  input  wire logic                          cmd_write,
  input  wire logic                          cmd_burst,
  input  wire logic [ADDR_W-1:0]             cmd_addr,
  input  wire logic [pssp_pkg::LANES-1:0]    cmd_byte_en,
  input  wire logic [pssp_pkg::DATA_W-1:0]   cmd_data,
  input  wire logic [pssp_pkg::LANES-1:0]    cmd_parity,
  input  wire logic                          pause,
  input  wire logic                          sleep,
  input  wire logic                          out_off,
  output logic                               rd_valid,
  input  wire logic                          rd_ready,
  output logic [pssp_pkg::DATA_W-1:0]        rd_data,
  output logic [pssp_pkg::LANES-1:0]         rd_parity
);
  import pssp_pkg::*;

  localparam int BW = DATA_W + LANES;
  localparam int PW = $clog2(BUF_DEPTH);

  logic     qual_n;
  logic     sleep_q;
  pssp_op_t last_kind;
  pssp_op_t p1;
  pssp_op_t p2;
  pssp_op_t p3;
  logic [BW-1:0] p1_word;
  logic [BW-1:0] p2_word;

  // Read buffer
  logic [BW-1:0]      fifo [0:BUF_DEPTH-1];
  logic [PW-1:0]      wptr;
  logic [PW-1:0]      rptr;
  logic [CNT_W-1:0]   fcount;

  // Pins are consumed at this edge only while qualifier is low
  wire adv      = ~qual_n; // [RULE2]
  wire can_bst  = cmd_burst & (last_kind != PSSP_IDLE); // [RULE16]

  pssp_op_t want_op;
  assign want_op = can_bst ? last_kind :
                   (cmd_write ? PSSP_WRITE : PSSP_READ); // [RULE18]

  // Credit: every read in flight owns a buffer slot
  wire [CNT_W-1:0] reads_out = CNT_W'(p1 == PSSP_READ) + CNT_W'(p2 == PSSP_READ)
                             + CNT_W'(p3 == PSSP_READ) + fcount;
  wire no_room = (want_op == PSSP_READ) & (reads_out >= CNT_W'(BUF_DEPTH));
  assign cmd_ready = adv & ~sleep_q & ~no_room;
  wire go     = cmd_valid & cmd_ready;
  wire push   = adv & (p3 == PSSP_READ); // [RULE19]
  wire full   = (fcount == CNT_W'(BUF_DEPTH));
  assign rd_valid = (fcount != '0);
  wire pop    = rd_valid & rd_ready;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      qual_n  <= 1'b0;
      sleep_q <= 1'b0;
      bus.out_drive_n <= 1'b0;
    end else begin
      qual_n  <= pause; // [RULE1]
      sleep_q <= sleep; // [RULE3]
      bus.out_drive_n <= out_off;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bus.chip_sel_a_n      <= 1'b1;
      bus.chip_sel_b        <= 1'b0;
      bus.chip_sel_c_n      <= 1'b1;
      bus.advance_or_load   <= 1'b0;
      bus.write_n           <= 1'b1;
      bus.byte_lane_write_n <= BW_IDLE;
      bus.addr              <= '0;
      last_kind <= PSSP_IDLE;
      p1 <= PSSP_IDLE;
      p2 <= PSSP_IDLE;
      p3 <= PSSP_IDLE;
      p1_word <= '0;
      p2_word <= '0;
      bus.host_drive_en <= 1'b0;
      bus.host_data     <= '0;
      bus.host_parity   <= '0;
    end else if (adv) begin
      bus.chip_sel_a_n      <= ~go; // [RULE11]
      bus.chip_sel_b        <= go;
      bus.chip_sel_c_n      <= ~go;
      bus.advance_or_load   <= go & can_bst; // [RULE16] [RULE17]
      bus.write_n           <= ~(go & (want_op == PSSP_WRITE)); // [RULE12]
      bus.byte_lane_write_n <= go ? ~cmd_byte_en : BW_IDLE; // [RULE13]
      bus.addr              <= cmd_addr;
      last_kind <= go ? want_op : PSSP_IDLE;
      p1 <= go ? want_op : PSSP_IDLE;
      p1_word <= {cmd_parity, cmd_data};
      p2 <= p1;
      p2_word <= p1_word;
      p3 <= p2;
      // Drive only in the write data cycle, never against a read
      bus.host_drive_en <= (p2 == PSSP_WRITE); // [RULE20] [RULE6]
      bus.host_data     <= p2_word[DATA_W-1:0];
      bus.host_parity   <= p2_word[BW-1:DATA_W]; // [RULE7]
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wptr   <= '0;
      rptr   <= '0;
      fcount <= '0;
    end else begin
      if (push & ~full) begin
        wptr <= PW'(wptr + 1'b1);
      end
      if (pop) begin
        rptr <= PW'(rptr + 1'b1);
      end
      fcount <= fcount + CNT_W'(push & ~full) - CNT_W'(pop);
    end
  end

  always_ff @(posedge mclk) begin
    if (push & ~full) begin
      fifo[wptr] <= {bus.parity_lines, bus.data_bus};
    end
  end

  assign rd_data   = fifo[rptr][DATA_W-1:0];
  assign rd_parity = fifo[rptr][BW-1:DATA_W];
  assign bus.clk_qualify_n = qual_n;
  assign bus.sleep_request = sleep_q;
  assign bus.burst_mode    = INTERLEAVED; // [RULE8]
endmodule : pssp_sram_host

// File: dv/pipelined_sync_sram_port_test.sv
// Testbench: two controller/SRAM pairs, pair 0 linear order, pair 1 interleaved.
// Assumes the design files under core/ are compiled first.
`timescale 1ns/1ns
module pipelined_sync_sram_port_test;
  import pssp_pkg::*;
  logic              mclk, resetn, cmd_valid, cmd_write, cmd_burst;
  logic              pause, sleep, out_off, rd_ready;
  logic [ADDR_W-1:0] cmd_addr;
  logic [LANES-1:0]  cmd_byte_en, cmd_parity;
  logic [DATA_W-1:0] cmd_data;
  logic [1:0]        rdy, rv, slp, ilv, drv;
  logic [DATA_W-1:0] rdd [2];
  logic [LANES-1:0]  rdp [2];
  logic [WORD_W-1:0] mem [int];
  logic [WORD_W-1:0] got [2][$];
  logic [WORD_W-1:0] exp [2][$];
  int                n_fail, num_checks, cyc;

  for (genvar g = 0; g < 2; g++) begin : pr
    pssp_if bus ();
    pssp_sram_host #(.INTERLEAVED(g == 1)) pssp_sram_host_i (.mclk, .resetn, .bus(bus.host),
      .cmd_valid, .cmd_ready(rdy[g]), .cmd_write, .cmd_burst, .cmd_addr, .cmd_byte_en,
      .cmd_data, .cmd_parity, .pause, .sleep, .out_off, .rd_valid(rv[g]), .rd_ready,
      .rd_data(rdd[g]), .rd_parity(rdp[g]));
    pssp_sram_dev pssp_sram_dev_i (.mclk, .resetn, .bus(bus.device), .sleeping(slp[g]),
      .interleaved(ilv[g]), .driving(drv[g]));
  end

  pssp_props pssp_props_i (.mclk, .resetn, .clk_qualify_n(pr[0].bus.clk_qualify_n),
    .chip_sel_a_n(pr[0].bus.chip_sel_a_n), .chip_sel_b(pr[0].bus.chip_sel_b),
    .chip_sel_c_n(pr[0].bus.chip_sel_c_n), .advance_or_load(pr[0].bus.advance_or_load),
    .write_n(pr[0].bus.write_n), .out_drive_n(pr[0].bus.out_drive_n),
    .sleep_request(pr[0].bus.sleep_request), .host_drive_en(pr[0].bus.host_drive_en),
    .dev_drive_en(pr[0].bus.dev_drive_en), .dev_data(pr[0].bus.dev_data),
    .dev_parity(pr[0].bus.dev_parity));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Collect every word popped from each read buffer
  always @(posedge mclk) begin
    for (int g = 0; g < 2; g++)
      if (rv[g] === 1'b1 && rd_ready === 1'b1) got[g].push_back({rdp[g], rdd[g]});
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic chk(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] want);
    num_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  function automatic int key(int g, logic [ADDR_W-1:0] a);
    return (g << ADDR_W) | int'(a);
  endfunction : key

  // Burst step k from base a: interleaved xor, linear add
  function automatic logic [ADDR_W-1:0] at(int g, logic [ADDR_W-1:0] a, int k);
    return {a[ADDR_W-1:2], g ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
  endfunction : at

  task automatic put(input logic w, b, input logic [ADDR_W-1:0] a,
                     input logic [LANES-1:0] be, input logic [DATA_W-1:0] d);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_burst = b;
    cmd_addr = a;
    cmd_byte_en = be;
    cmd_data = d;
    cmd_parity = d[3:0] ^ d[11:8];
    for (int i = 0; i < 40 && rdy !== 2'b11; i++) @(posedge mclk) #1;
    @(posedge mclk);
    #1;
  endtask : put

  task automatic wr(input logic b, input logic [ADDR_W-1:0] a, input int k,
                    input logic [LANES-1:0] be, input logic [DATA_W-1:0] d);
    logic [WORD_W-1:0] w;
    put(1'b1, b, a, be, d);
    for (int g = 0; g < 2; g++) begin
      w = mem[key(g, at(g, a, k))];
      for (int l = 0; l < LANES; l++) begin
        if (be[l]) begin
          w[l*LANE_W +: LANE_W] = d[l*LANE_W +: LANE_W];
          w[DATA_W+l] = cmd_parity[l];
        end
      end
      mem[key(g, at(g, a, k))] = w;
    end
  endtask : wr

  task automatic rd(input logic b, input logic [ADDR_W-1:0] a, input int k);
    put(1'b0, b, a, 4'h0, 32'h0);
    for (int g = 0; g < 2; g++) exp[g].push_back(mem[key(g, at(g, a, k))]);
  endtask : rd

  task automatic drain;
    cmd_valid = 1'b0;
    for (int i = 0; i < 60 && got[1].size() < exp[1].size(); i++) @(posedge mclk) #1;
    for (int g = 0; g < 2; g++) begin
      chk(WORD_W'(got[g].size()), WORD_W'(exp[g].size()));
      while (got[g].size() > 0 && exp[g].size() > 0)
        chk(got[g].pop_front(), exp[g].pop_front());
      got[g] = {};
      exp[g] = {};
    end
  endtask : drain

  task automatic t_basic;
    wr(1'b0, 17'h10, 0, 4'hf, 32'h1122_3344);
    wr(1'b0, 17'h11, 0, 4'hf, 32'hcafe_f00d);
    wr(1'b0, 17'h10, 0, 4'h5, 32'haabb_ccdd);
    rd(1'b0, 17'h11, 0);
    rd(1'b0, 17'h11, 0);
    rd(1'b0, 17'h10, 0);
    wr(1'b0, 17'h11, 0, 4'ha, 32'h0bad_5eed);
    rd(1'b0, 17'h10, 0);
    drain();
  endtask : t_basic

  task automatic t_burst;
    for (int k = 0; k < 4; k++) wr(k != 0, 17'h21, k, 4'hf, 32'h5a00_0000 + k);
    for (int k = 0; k < 4; k++) rd(1'b0, 17'h20 + k, 0);
    drain();
    // Read credit allows two back-to-back reads, so bursts of two
    for (int j = 0; j < 2; j++) begin
      rd(1'b0, 17'h22 + j, 0);
      rd(1'b1, 17'h22 + j, 1);
      drain();
    end
  endtask : t_burst

  task automatic t_stall;
    rd_ready = 1'b0;
    rd(1'b0, 17'h20, 0);
    rd(1'b0, 17'h11, 0);
    fork
      rd(1'b0, 17'h10, 0);
      begin
        repeat (8) @(posedge mclk);
        #2;
        chk({34'h0, rdy}, 36'h0);
        chk({34'h0, rv}, 36'h3);
        rd_ready = 1'b1;
      end
    join
    drain();
  endtask : t_stall

  task automatic t_pause;
    rd(1'b0, 17'h23, 0);
    cmd_valid = 1'b0;
    pause = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    chk(WORD_W'(got[0].size()), 36'h0);
    pause = 1'b0;
    drain();
  endtask : t_pause

  task automatic t_sleep;
    sleep = 1'b1;
    out_off = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    chk({34'h0, slp}, 36'h3);
    chk({34'h0, rdy}, 36'h0);
    chk({34'h0, drv}, 36'h0);
    sleep = 1'b0;
    out_off = 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    rd(1'b0, 17'h11, 0);
    drain();
  endtask : t_sleep

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  initial begin
    {cmd_valid, cmd_write, cmd_burst, pause, sleep, out_off} = 6'h0;
    cmd_addr = 17'h0;
    cmd_byte_en = 4'h0;
    cmd_parity = 4'h0;
    cmd_data = 32'h0;
    rd_ready = 1'b1;
    resetn = 1'b0;
    repeat (10) @(posedge mclk);
    #1;
    resetn = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk({34'h0, ilv}, 36'h2);
    t_basic();
    t_burst();
    t_stall();
    t_pause();
    t_sleep();
    give_verdict();
  end
endmodule : pipelined_sync_sram_port_test

// File: dv/pssp_props.sv
// Checker on the pin bundle between the controller and SRAM ends.
// Assumes one clock mclk and asynchronous active-low resetn.
`timescale 1ns/1ns
module pssp_props (
  input wire logic                        mclk,
  input wire logic                        resetn,
  input wire logic                        clk_qualify_n,
  input wire logic                        chip_sel_a_n,
  input wire logic                        chip_sel_b,
  input wire logic                        chip_sel_c_n,
  input wire logic                        advance_or_load,
  input wire logic                        write_n,
  input wire logic                        out_drive_n,
  input wire logic                        sleep_request,
  input wire logic                        host_drive_en,
  input wire logic                        dev_drive_en,
  input wire logic [pssp_pkg::DATA_W-1:0] dev_data,
  input wire logic [pssp_pkg::LANES-1:0]  dev_parity
);
  import pssp_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire q     = !clk_qualify_n;
  wire sel   = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
  wire ld    = q && !advance_or_load;
  wire wr_ld = ld && sel && !write_n;
  wire rd_ld = ld && sel && write_n;
  wire ds_ld = ld && !sel;
  wire calm  = !out_drive_n && !sleep_request;

  a_write_data_off: assert property (wr_ld ##1 q |=> !dev_drive_en)
    else $error("device drove in write data cycle");
  a_deselect_off: assert property (ds_ld ##1 q |=> !dev_drive_en)
    else $error("device drove after deselect");
  a_oe_off: assert property (out_drive_n [*4] |-> !dev_drive_en)
    else $error("device drove with output drive off");
  a_read_drive: assert property (calm [*4] ##0 rd_ld ##1 (q && calm) |=> dev_drive_en)
    else $error("read data not driven one edge later");
  a_freeze_hold: assert property (clk_qualify_n && !sleep_request |=> $stable({dev_data, dev_parity}))
    else $error("outputs changed on masked edge");
  a_no_clash: assert property (!(dev_drive_en && host_drive_en))
    else $error("both ends drive the data lines");
  a_write_data_time: assert property (wr_ld ##1 q |=> host_drive_en)
    else $error("write data not presented two edges later");
  a_sleep_off: assert property (sleep_request [*4] |-> !dev_drive_en)
    else $error("device drove while asleep");

  cover property (wr_ld);
  cover property (rd_ld ##2 dev_drive_en);
  cover property (ld && sel ##1 q && advance_or_load);
  cover property (clk_qualify_n [*3]);
endmodule : pssp_props
